// ===== src/cpi_defs.svh
`ifndef CPI_DEFS_SVH
`define CPI_DEFS_SVH

`define CPI_OFF_CTL        12'h000
`define CPI_OFF_SPLIT      12'h008
`define CPI_OFF_AACK       12'h020
`define CPI_OFF_AQRY       12'h028
`define CPI_OFF_APR        12'h0D0
`define CPI_OFF_NSAPR      12'h0E0
`define CPI_APR_MASK       12'hFF0

`define CPI_ID_SPURIOUS    10'h3FF
`define CPI_ID_RSV_LO      10'h3FC
`define CPI_SGI_LIMIT      10'h010

`define CPI_SPLIT_S_RST    3'h2
`define CPI_SPLIT_NS_RST   3'h3
`define CPI_SPLIT_MAX      3'h7
`define CPI_APR_RST        32'h0000_0000

`define CPI_CTL_EN_G0      0
`define CPI_CTL_EN_G1      1
`define CPI_CTL_FIQ_EN     3
`define CPI_CTL_COMMON_BINARY_POINT       4
`define CPI_CTL_S_BYP_LO   5
`define CPI_CTL_EOI_S      9
`define CPI_CTL_S_EOI_NS   10
`define CPI_CTL_NS_EN_G1   0
`define CPI_CTL_NS_BYP_LO  5
`define CPI_CTL_NS_EOI     9

`endif

// ===== src/cpi_pkg.sv
package cpi_pkg;

   typedef struct packed {
      logic       valid;
      logic [7:0] prio;
      logic [9:0] id;
      logic [2:0] src;
   } cpi_cand_s;

   typedef logic [31:0] cpi_word_t;

endpackage : cpi_pkg

// ===== src/cpi_pend_if.sv
interface cpi_pend_if;
   import cpi_pkg::*;

   cpi_cand_s  cand0;
   cpi_cand_s  cand1;
   logic [1:0] dist_en;
   logic [1:0] cpu_en;
   cpi_word_t  word;
   logic       real_top;

   modport fmt (
      input  cand0,
      input  cand1,
      input  dist_en,
      input  cpu_en,
      output word,
      output real_top
   );

   modport user (
      output cand0,
      output cand1,
      output dist_en,
      output cpu_en,
      input  word,
      input  real_top
   );
endinterface : cpi_pend_if

// ===== src/cpi_id_fmt.sv
`include "cpi_defs.svh"

module cpi_id_fmt
   import cpi_pkg::*;
(
   cpi_pend_if.fmt p
);

   wire       elig0;
   wire       elig1;
   wire       top_g1;
   wire       top_any;
   wire       real_g1;
   wire [9:0] id_sel;
   wire [2:0] src_sel;

   // Candidates of a group disabled in the distributor, or carrying a special code, drop out.
   assign elig0   = p.cand0.valid & p.dist_en[0] & (p.cand0.id < `CPI_ID_RSV_LO);
   assign elig1   = p.cand1.valid & p.dist_en[1] & (p.cand1.id < `CPI_ID_RSV_LO);
   // Lower priority value wins; a tie goes to Group 0.
   assign top_g1  = elig1 & (~elig0 | (p.cand1.prio < p.cand0.prio));
   assign top_any = elig0 | elig1;
   // Group 0 on top, or Group 1 masked in this interface, reads as spurious.
   assign real_g1 = top_any & top_g1 & p.cpu_en[1];
   assign id_sel  = real_g1 ? p.cand1.id : `CPI_ID_SPURIOUS;
   assign src_sel = (real_g1 && (p.cand1.id < `CPI_SGI_LIMIT)) ? p.cand1.src : 3'h0;

   assign p.word     = {8'h00, 11'h000, src_sel, id_sel};
   assign p.real_top = real_g1;

endmodule : cpi_id_fmt

// ===== src/cpi_apr_bank.sv
`include "cpi_defs.svh"

module cpi_apr_bank
   import cpi_pkg::*;
#(
   parameter int NUM = 4
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        we_in,
   input  wire logic [1:0]  idx_in,
   input  wire logic [31:0] wdata_in,
   output logic      [31:0] rdata_out,
   output logic             any_out
);

   logic [31:0] word_reg [4];
   logic [3:0]  nz;

   if (NUM < 1 || NUM > 4) begin : g_bad_num
      $error("cpi_apr_bank: NUM must be 1 to 4");
   end

   for (genvar i = 0; i < 4; i++) begin : g_word
      if (i < NUM) begin : g_impl
         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               word_reg[i] <= `CPI_APR_RST;
            end else if (we_in && (idx_in == 2'(i))) begin
               word_reg[i] <= wdata_in;
            end
         end
      end else begin : g_absent
         assign word_reg[i] = 32'h0000_0000;
      end
      assign nz[i] = |word_reg[i];
   end

   assign rdata_out = word_reg[idx_in];
   // All-zero contents mean nothing is active.
   assign any_out   = |nz;

endmodule : cpi_apr_bank

// ===== src/cpi_regs.sv
// Functional notes
// - Alias query returns top Group 1 identifier.
// - Group 0 on top reads 1023.
// - Disabled groups are ignored when choosing top.
// - Group 1 masked in interface reads 1023.
// - Alias query ignores security when disable 0.
// - Identifier in bits 12:0, rest zero.
// - Identifiers 1020 to 1023 are special codes.
// - Source CPU bits only for software interrupts.
// - Alias acknowledge read also acknowledges interrupt.
// - Alias acknowledge ignores security when disable 0.
// - Active priorities reset zero; zero means idle.
// - Active priorities banked when security disable 0.
// - Extra active priority words need more bits.
// - Security disabled: separate Group 1 active words.
// - Split point field divides priority in two.
// - System register mode: split point reads zero.
// - Two states: banked split point per group.
// - One state: common control picks group coverage.
// - Interface control banked with different layouts.
// - Separate end of interrupt controls per state.
`include "cpi_defs.svh"

module cpi_regs
   import cpi_pkg::*;
#(
   parameter int PRIO_BITS = 7
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        security_disable_in,
   input  wire logic        sysreg_enable_in,
   input  wire logic [1:0]  dist_grp_en_in,
   input  wire logic        g0_pend_valid_in,
   input  wire logic [7:0]  g0_pend_prio_in,
   input  wire logic [9:0]  g0_pend_id_in,
   input  wire logic [2:0]  g0_pend_src_in,
   input  wire logic        g1_pend_valid_in,
   input  wire logic [7:0]  g1_pend_prio_in,
   input  wire logic [9:0]  g1_pend_id_in,
   input  wire logic [2:0]  g1_pend_src_in,
   input  wire logic        reg_req_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_ns_in,
   input  wire logic [11:0] reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   output logic      [31:0] reg_rdata_out,
   output logic             reg_ack_out,
   output logic             ack_pulse_out,
   output logic      [9:0]  ack_id_out,
   output logic      [1:0]  grp_en_out,
   output logic             fiq_en_out,
   output logic             common_binary_point_out,
   output logic      [3:0]  bypass_dis_out,
   output logic             eoi_mode_s_out,
   output logic             eoi_mode_ns_out,
   output logic      [2:0]  g0_split_out,
   output logic      [2:0]  g1_split_out,
   output logic             active_any_out
);

   localparam int APR_NUM = (PRIO_BITS == 7) ? 4 : ((PRIO_BITS == 6) ? 2 : 1);

   if (PRIO_BITS < 5 || PRIO_BITS > 7) begin : g_bad_prio
      $error("cpi_regs: PRIO_BITS must be 5 to 7");
   end

   // Control state.
   logic        en_g0_reg;
   logic        en_g1_reg;
   logic        fiq_en_reg;
   logic        common_binary_point_reg;
   logic [3:0]  byp_reg;
   logic        eoi_s_reg;
   logic        eoi_ns_reg;
   logic [2:0]  split_s_reg;
   logic [2:0]  split_ns_reg;
   logic [31:0] rdata_reg;
   logic        rack_reg;
   logic        ack_pulse_reg;
   logic [9:0]  ack_id_reg;

   // Access decode.
   wire         acc_ns;
   wire         rd_req;
   wire         wr_req;
   wire         hit_ctl;
   wire         hit_split;
   wire         hit_aack;
   wire         hit_aqry;
   wire         hit_apr;
   wire         hit_nsapr;
   wire [1:0]   apr_idx;
   wire         sel_g0_apr;
   wire         sel_g1_apr;
   wire [31:0]  apr_g0_rd;
   wire [31:0]  apr_g1_rd;
   wire         apr_g0_any;
   wire         apr_g1_any;

   // Register views and next values.
   wire [31:0]  ctl_s_view;
   wire [31:0]  ctl_ns_view;
   wire [2:0]   split_s_inc;
   wire [2:0]   split_ns_view;
   wire [31:0]  split_view;
   wire [31:0]  rd_next;
   wire         ctl_wr;
   wire         ctl_wr_s;
   wire         ctl_wr_ns;
   wire         split_wr_s;
   wire         split_wr_ns;
   wire         ack_take;
   wire         split_ok;
   wire         rd_sel_id;
   wire         rd_sel_apr;
   wire [31:0]  ctl_view;
   wire [31:0]  apr_rd;
   wire [9:0]   ack_id_next;

   cpi_pend_if p_if ();

   // Security disabled means every access is treated as one single state.
   assign acc_ns = reg_ns_in & ~security_disable_in;
   assign rd_req = reg_req_in & ~reg_wr_in;
   assign wr_req = reg_req_in & reg_wr_in;

   assign hit_ctl   = (reg_addr_in == `CPI_OFF_CTL);
   assign hit_split = (reg_addr_in == `CPI_OFF_SPLIT);
   assign hit_aack  = (reg_addr_in == `CPI_OFF_AACK);
   assign hit_aqry  = (reg_addr_in == `CPI_OFF_AQRY);
   assign hit_apr   = ((reg_addr_in & `CPI_APR_MASK) == `CPI_OFF_APR) &
                      (reg_addr_in[1:0] == 2'h0);
   assign hit_nsapr = ((reg_addr_in & `CPI_APR_MASK) == `CPI_OFF_NSAPR) &
                      (reg_addr_in[1:0] == 2'h0);
   assign apr_idx   = reg_addr_in[3:2];

   // Secure or single-state view of the active words keeps Group 0; the banked
   // Non-secure view and the separate Non-secure words keep Group 1.
   assign sel_g0_apr = ~sysreg_enable_in & hit_apr & ~acc_ns;
   assign sel_g1_apr = ~sysreg_enable_in &
                       ((hit_apr & acc_ns) | (hit_nsapr & ~acc_ns));

   cpi_apr_bank #(
      .NUM       (APR_NUM)
   ) u_apr_g0 (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .we_in     (wr_req & sel_g0_apr),
      .idx_in    (apr_idx),
      .wdata_in  (reg_wdata_in),
      .rdata_out (apr_g0_rd),
      .any_out   (apr_g0_any)
   );

   cpi_apr_bank #(
      .NUM       (APR_NUM)
   ) u_apr_g1 (
      .clk_in    (clk_in),
      .rst_in    (rst_in),
      .we_in     (wr_req & sel_g1_apr),
      .idx_in    (apr_idx),
      .wdata_in  (reg_wdata_in),
      .rdata_out (apr_g1_rd),
      .any_out   (apr_g1_any)
   );

   // Pending-query formatting.
   assign p_if.cand0   = '{valid: g0_pend_valid_in, prio: g0_pend_prio_in,
                           id: g0_pend_id_in, src: g0_pend_src_in};
   assign p_if.cand1   = '{valid: g1_pend_valid_in, prio: g1_pend_prio_in,
                           id: g1_pend_id_in, src: g1_pend_src_in};
   assign p_if.dist_en = dist_grp_en_in;
   assign p_if.cpu_en  = {en_g1_reg, en_g0_reg};

   cpi_id_fmt u_fmt (
      .p (p_if.fmt)
   );

   // Secure layout, also used when security is disabled.
   assign ctl_s_view = {21'h000000,
                        eoi_ns_reg,
                        eoi_s_reg,
                        byp_reg,
                        common_binary_point_reg,
                        fiq_en_reg,
                        1'b0,
                        en_g1_reg,
                        en_g0_reg};
   // Non-secure layout shows only the Group 1 controls.
   assign ctl_ns_view = {22'h000000,
                         eoi_ns_reg,
                         2'h0,
                         byp_reg[3:2],
                         4'h0,
                         en_g1_reg};

   assign ctl_wr    = wr_req & hit_ctl;
   assign ctl_wr_s  = ctl_wr & ~acc_ns;
   assign ctl_wr_ns = ctl_wr & acc_ns;

   // Non-secure reads see the Secure split plus one, saturated, under common control.
   assign split_s_inc   = (split_s_reg == `CPI_SPLIT_MAX) ? `CPI_SPLIT_MAX :
                          split_s_reg + 3'h1;
   assign split_ns_view = common_binary_point_reg ? split_s_inc : split_ns_reg;
   assign split_view    = sysreg_enable_in ? 32'h0000_0000 :
                          {29'h00000000, acc_ns ? split_ns_view : split_s_reg};
   assign split_ok      = hit_split & ~sysreg_enable_in;
   assign split_wr_s    = wr_req & split_ok & ~acc_ns;
   assign split_wr_ns   = wr_req & split_ok & acc_ns & ~common_binary_point_reg;

   // The aliased pair ignore the security attribute of the access.
   assign ack_take    = rd_req & hit_aack & p_if.real_top;
   // The acknowledged identifier is taken from the formatted word, so it matches the read.
   assign ack_id_next = p_if.word[9:0];

   // Read selection: the security view of the access picks the control layout.
   assign ctl_view   = acc_ns ? ctl_ns_view : ctl_s_view;
   assign rd_sel_id  = hit_aack | hit_aqry;
   assign rd_sel_apr = sel_g0_apr | sel_g1_apr;
   assign apr_rd     = sel_g0_apr ? apr_g0_rd : apr_g1_rd;

   assign rd_next = hit_ctl    ? ctl_view :
                    hit_split  ? split_view :
                    rd_sel_id  ? p_if.word :
                    rd_sel_apr ? apr_rd :
                    32'h0000_0000;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         en_g0_reg  <= 1'b0;
         en_g1_reg  <= 1'b0;
         fiq_en_reg <= 1'b0;
         common_binary_point_reg   <= 1'b0;
         byp_reg    <= 4'h0;
         eoi_s_reg  <= 1'b0;
         eoi_ns_reg <= 1'b0;
      end else if (ctl_wr_s) begin
         en_g0_reg  <= reg_wdata_in[`CPI_CTL_EN_G0];
         en_g1_reg  <= reg_wdata_in[`CPI_CTL_EN_G1];
         fiq_en_reg <= reg_wdata_in[`CPI_CTL_FIQ_EN];
         common_binary_point_reg   <= reg_wdata_in[`CPI_CTL_COMMON_BINARY_POINT];
         byp_reg    <= reg_wdata_in[`CPI_CTL_S_BYP_LO +: 4];
         eoi_s_reg  <= reg_wdata_in[`CPI_CTL_EOI_S];
         eoi_ns_reg <= reg_wdata_in[`CPI_CTL_S_EOI_NS];
      end else if (ctl_wr_ns) begin
         en_g1_reg    <= reg_wdata_in[`CPI_CTL_NS_EN_G1];
         byp_reg[3:2] <= reg_wdata_in[`CPI_CTL_NS_BYP_LO +: 2];
         eoi_ns_reg   <= reg_wdata_in[`CPI_CTL_NS_EOI];
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         split_s_reg  <= `CPI_SPLIT_S_RST;
         split_ns_reg <= `CPI_SPLIT_NS_RST;
      end else begin
         if (split_wr_s) begin
            split_s_reg <= reg_wdata_in[2:0];
         end
         if (split_wr_ns) begin
            split_ns_reg <= reg_wdata_in[2:0];
         end
      end
   end

   // Read data, answer strobe and acknowledge pulse follow the request by one cycle.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rdata_reg     <= 32'h0000_0000;
         rack_reg      <= 1'b0;
         ack_pulse_reg <= 1'b0;
         ack_id_reg    <= 10'h000;
      end else begin
         rack_reg      <= reg_req_in;
         ack_pulse_reg <= ack_take;
         if (rd_req) begin
            rdata_reg <= rd_next;
         end
         if (ack_take) begin
            ack_id_reg <= ack_id_next;
         end
      end
   end

   assign reg_rdata_out  = rdata_reg;
   assign reg_ack_out    = rack_reg;
   assign ack_pulse_out  = ack_pulse_reg;
   assign ack_id_out     = ack_id_reg;
   assign grp_en_out     = {en_g1_reg, en_g0_reg};
   assign fiq_en_out     = fiq_en_reg;
   assign bypass_dis_out = byp_reg;
   assign eoi_mode_s_out  = eoi_s_reg;
   assign eoi_mode_ns_out = eoi_ns_reg;
   assign common_binary_point_out = common_binary_point_reg;

   // Secure split governs Group 0; Group 1 follows it only under common control.
   assign g0_split_out   = split_s_reg;
   assign g1_split_out   = common_binary_point_reg ? split_s_reg : split_ns_reg;
   assign active_any_out = apr_g0_any | apr_g1_any;

endmodule : cpi_regs

// ===== tb/cpi_pend_src.sv
module cpi_pend_src
   import cpi_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic new_in,
   output cpi_cand_s c0_out,
   output cpi_cand_s c1_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // Close priorities force ties; some identifiers are low or reserved.
   function automatic cpi_cand_s pick();
      pick = 22'($urandom);
      pick.prio = 8'($urandom_range(3));
      case ($urandom_range(3))
         0: pick.id = 10'h3FC + 10'($urandom_range(3));
         1: pick.id = 10'($urandom_range(15));
         default: ;
      endcase
   endfunction : pick

   initial c0_out = '0;
   initial c1_out = '0;

   always @(posedge clk_in) begin
      if (new_in) begin
         c0_out <= #1 pick();
         c1_out <= #1 pick();
      end
   end
endmodule : cpi_pend_src

// ===== tb/cpi_regs_sva.sv
module cpi_regs_sva (
   input wire logic        clk_in,
   input wire logic        rst_in,
   input wire logic        sysreg_enable_in,
   input wire logic [1:0]  dist_grp_en_in,
   input wire logic        g0_pend_valid_in,
   input wire logic [7:0]  g0_pend_prio_in,
   input wire logic [9:0]  g0_pend_id_in,
   input wire logic        g1_pend_valid_in,
   input wire logic [7:0]  g1_pend_prio_in,
   input wire logic        reg_req_in,
   input wire logic        reg_wr_in,
   input wire logic [11:0] reg_addr_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic        ack_pulse_out,
   input wire logic [9:0]  ack_id_out,
   input wire logic [1:0]  grp_en_out,
   input wire logic        common_binary_point_out,
   input wire logic [2:0]  g0_split_out,
   input wire logic [2:0]  g1_split_out,
   input wire logic        active_any_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);

   wire rd_q = reg_req_in && !reg_wr_in;
   wire alias_rd = rd_q && (reg_addr_in == 12'h020 || reg_addr_in == 12'h028);
   wire split_rd = rd_q && reg_addr_in == 12'h008;
   wire split_wr = reg_req_in && reg_wr_in && reg_addr_in == 12'h008;
   wire g0_win = g0_pend_valid_in && dist_grp_en_in[0] && g0_pend_id_in < 10'h3FC
      && (!g1_pend_valid_in || g0_pend_prio_in <= g1_pend_prio_in);

   a_id_upper_zero: assert property (alias_rd |=> reg_rdata_out[31:13] == 19'h0)
      else $error("alias read upper bits not zero");
   a_src_only_sgi: assert property (alias_rd |=> reg_rdata_out[9:4] == 6'h0
      || reg_rdata_out[12:10] == 3'h0) else $error("source bits on non-sgi id");
   a_ack_pulse_cause: assert property (ack_pulse_out |-> $past(rd_q && reg_addr_in == 12'h020))
      else $error("acknowledge without alias acknowledge read");
   a_ack_id_plain: assert property (ack_pulse_out |-> ack_id_out < 10'h3FC
      && ack_id_out == reg_rdata_out[9:0]) else $error("acknowledged id wrong");
   a_spur_no_ack: assert property (alias_rd ##1 reg_rdata_out[9:0] == 10'h3FF |-> !ack_pulse_out)
      else $error("spurious read acknowledged");
   a_g0_top_spur: assert property (alias_rd && g0_win |=> reg_rdata_out[9:0] == 10'h3FF)
      else $error("group 0 on top not spurious");
   a_g1_masked_spur: assert property (alias_rd && !grp_en_out[1]
      |=> reg_rdata_out[9:0] == 10'h3FF) else $error("masked group 1 not spurious");
   a_split_common: assert property (common_binary_point_out |-> g1_split_out == g0_split_out)
      else $error("common split point not shared");
   a_split_raz: assert property (split_rd && sysreg_enable_in |=> reg_rdata_out == 32'h0)
      else $error("split point not read as zero");
   a_split_wi: assert property (split_wr && sysreg_enable_in
      |=> $stable(g0_split_out) && $stable(g1_split_out)) else $error("split point written");
   a_active_reset: assert property ($fell(rst_in) |-> !active_any_out)
      else $error("active priorities not idle after reset");

   c_real_ack: cover property (ack_pulse_out);
   c_common: cover property (common_binary_point_out && split_rd);
   c_active: cover property (active_any_out);
endmodule : cpi_regs_sva

bind cpi_regs cpi_regs_sva u_sva (.*);

// ===== tb/cpi_regs_tb.sv
module cpi_regs_tb
   import cpi_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_in = 0, rst_in = 1, ds = 0, sre = 0, req = 0, wr = 0, ns = 0, nw = 0, sn;
   logic [1:0]  de = 2'h3, ge;
   logic [11:0] addr = 12'h000, a;
   logic [31:0] wd = 32'h0, rd, x, e;
   wire  [31:0] rdata;
   wire  [9:0]  aid;
   wire  [1:0]  gen;
   wire  [3:0]  byp;
   wire         fiq;
   wire  [2:0]  s0, s1;
   wire         ack, apls, cbp, act, eos, eon;
   cpi_cand_s   c0, c1;
   int          miscompares = 0, cmp_count = 0;

   always #10 clk_in = ~clk_in;

   cpi_pend_src u_src (.clk_in(clk_in), .new_in(nw), .c0_out(c0), .c1_out(c1));

   cpi_regs #(.PRIO_BITS(6)) u_dut (
      .clk_in(clk_in), .rst_in(rst_in), .security_disable_in(ds), .sysreg_enable_in(sre),
      .dist_grp_en_in(de), .g0_pend_valid_in(c0.valid), .g0_pend_prio_in(c0.prio),
      .g0_pend_id_in(c0.id), .g0_pend_src_in(c0.src), .g1_pend_valid_in(c1.valid),
      .g1_pend_prio_in(c1.prio), .g1_pend_id_in(c1.id), .g1_pend_src_in(c1.src),
      .reg_req_in(req), .reg_wr_in(wr), .reg_ns_in(ns), .reg_addr_in(addr),
      .reg_wdata_in(wd), .reg_rdata_out(rdata), .reg_ack_out(ack), .ack_pulse_out(apls),
      .ack_id_out(aid), .grp_en_out(gen), .fiq_en_out(fiq), .common_binary_point_out(cbp),
      .bypass_dis_out(byp), .eoi_mode_s_out(eos), .eoi_mode_ns_out(eon), .g0_split_out(s0),
      .g1_split_out(s1), .active_any_out(act));

   // Expected alias word: eligible candidates only, ties go to Group 0.
   function automatic logic [31:0] exp_word(cpi_cand_s p, cpi_cand_s q, logic [1:0] d, g);
      logic e0, e1;
      e0 = p.valid && d[0] && p.id < 1020;
      e1 = q.valid && d[1] && q.id < 1020;
      if (e1 && (!e0 || q.prio < p.prio) && g[1])
         return {19'h0, q.id < 16 ? q.src : 3'h0, q.id};
      return 32'h3FF;
   endfunction : exp_word

   task automatic chk(logic [31:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic acc(logic w, n, logic [11:0] ad, logic [31:0] d = 32'h0);
      @(posedge clk_in) #1;
      {req, wr, ns, addr, wd} = {1'b1, w, n, ad, d};
      @(posedge clk_in) #1;
      req = 0;
      rd = rdata;
      chk(ack, 1);
   endtask : acc

   task automatic rchk(logic n, logic [11:0] ad, logic [31:0] ex);
      acc(0, n, ad);
      chk(rd, ex);
   endtask : rchk

   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   initial begin
      #60000;
      miscompares++;
      report_and_stop();
   end

   initial begin
      void'($urandom(41619));
      repeat (4) @(posedge clk_in);
      #1 rst_in = 0;
      rchk(0, 12'h008, 32'h2);
      rchk(1, 12'h008, 32'h3);
      for (int n = 0; n < 4; n++) begin
         rchk(0, 12'h0D0 + 12'(4 * n), 32'h0);
      end
      chk(act, 0);
      $display("Test reset values done");
      for (int n = 0; n < 4; n++) begin
         x = $urandom | 32'h1;
         acc(1, 0, 12'h0D0 + 12'(4 * n), x);
         acc(1, 1, 12'h0D0 + 12'(4 * n), ~x);
         rchk(0, 12'h0D0 + 12'(4 * n), n < 2 ? x : 32'h0);
         rchk(1, 12'h0D0 + 12'(4 * n), n < 2 ? ~x : 32'h0);
      end
      chk(act, 1);
      rst_in = 1;
      @(posedge clk_in) #1 rst_in = 0;
      chk(act, 0);
      rchk(0, 12'h0D0, 32'h0);
      ds = 1;
      x = $urandom;
      acc(1, 0, 12'h0D0, x);
      acc(1, 0, 12'h0E0, ~x);
      rchk(0, 12'h0D0, x);
      rchk(1, 12'h0D0, x);
      rchk(0, 12'h0E0, ~x);
      for (int n = 0; n < 2; n++) begin
         acc(1, 0, 12'h0D0 + 12'(4 * n));
         acc(1, 0, 12'h0E0 + 12'(4 * n));
      end
      chk(act, 0);
      ds = 0;
      $display("Test active priorities done");
      acc(1, 0, 12'h008, 32'hFFFF_FFF5);
      acc(1, 1, 12'h008, 32'h1);
      rchk(0, 12'h008, 32'h5);
      chk(s0, 5);
      chk(s1, 1);
      acc(1, 0, 12'h000, 32'h10);
      chk(cbp, 1);
      chk(s1, 5);
      acc(1, 1, 12'h008, 32'h2);
      rchk(1, 12'h008, 32'h6);
      acc(1, 0, 12'h008, 32'h7);
      rchk(1, 12'h008, 32'h7);
      sre = 1;
      acc(1, 0, 12'h008, 32'h1);
      rchk(0, 12'h008, 32'h0);
      sre = 0;
      rchk(0, 12'h008, 32'h7);
      $display("Test split point done");
      acc(1, 0, 12'h000, 32'h400);
      chk(eon, 1);
      chk(eos, 0);
      rchk(1, 12'h000, 32'h200);
      acc(1, 1, 12'h000, 32'h1);
      rchk(0, 12'h000, 32'h2);
      chk(eon, 0);
      acc(1, 0, 12'h000, 32'h8000_03EC);
      chk(fiq, 1);
      chk(byp, 4'hF);
      chk(eos, 1);
      chk(gen, 2'h0);
      rchk(0, 12'h000, 32'h3E8);
      rchk(1, 12'h000, 32'h60);
      rchk(0, 12'h030, 32'h0);
      $display("Test control banking done");
      repeat (80) begin
         nw = 1;
         {de, ge, sn} = 5'($urandom);
         @(posedge clk_in) #1 nw = 0;
         acc(1, 0, 12'h000, 32'(ge));
         chk(gen, ge);
         a = $urandom_range(1) ? 12'h020 : 12'h028;
         e = exp_word(c0, c1, de, ge);
         rchk(sn, a, e);
         chk(apls, a == 12'h020 && e < 1020);
         if (apls === 1'b1)
            chk(aid, e[9:0]);
      end
      $display("Test pending query done");
      report_and_stop();
   end
endmodule : cpi_regs_tb
